//--- bench/pwm_time_base_lowpower_props.sv
// port assertions for the pwm time base: bus handshakes and wake-up
// assumes binding to pwm_time_base_lowpower, one clock domain
`timescale 1ns/1ns
`default_nettype none
module pwm_time_base_lowpower_props (
    input wire logic aclk,            // clock
    input wire logic aresetn,         // sync reset, low
    input wire logic s_axi_awvalid,   // aw valid
    input wire logic s_axi_awready,   // aw ready
    input wire logic s_axi_wvalid,    // w valid
    input wire logic s_axi_wready,    // w ready
    input wire logic s_axi_bvalid,    // b valid
    input wire logic s_axi_bready,    // b ready
    input wire logic s_axi_arvalid,   // ar valid
    input wire logic s_axi_arready,   // ar ready
    input wire logic s_axi_rvalid,    // r valid
    input wire logic s_axi_rready,    // r ready
    input wire logic cpu_sleep,       // sleep
    input wire logic fault_input_a_n, // fault a
    input wire logic fault_input_b_n, // fault b
    input wire logic wake_request     // wake
);
    default clocking dclk @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    wake_on_fault_a: assert property (
        cpu_sleep && !(fault_input_a_n && fault_input_b_n) |=> wake_request)
        else $error("wake missing after fault in sleep");
    wake_quiet_a: assert property (
        !(cpu_sleep && !(fault_input_a_n && fault_input_b_n))
        |=> !wake_request) else $error("wake without cause");
    read_lat_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    write_lat_a: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid) else $error("write answer dropped");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid) else $error("read answer dropped");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    aw_block_a: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
endmodule : pwm_time_base_lowpower_props
bind pwm_time_base_lowpower pwm_time_base_lowpower_props i_props (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .cpu_sleep(cpu_sleep), .fault_input_a_n(fault_input_a_n),
    .fault_input_b_n(fault_input_b_n), .wake_request(wake_request)
);
`default_nettype wire

//--- bench/pwm_time_base_lowpower_tb_top.sv
// directed tests of the pwm time base through its axi4-lite registers
// assumes package, header, interface and design compiled before it
`timescale 1ns/1ns
`default_nettype none
`include "pwm_tb_defines.svh"
module pwm_time_base_lowpower_tb_top;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        cpu_idle, cpu_sleep, flt_a_n, flt_b_n;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, c1, c2;
    wire         awready, wready, bvalid, arready, rvalid, wake, trig, irq;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    int          bad_count, checks_done, pulses, last;

    pwm_time_base_lowpower i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
        .fault_input_a_n(flt_a_n), .fault_input_b_n(flt_b_n),
        .wake_request(wake), .special_trigger(trig), .irq(irq)
    );

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic chk(input string n, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        rready <= 1'b0;
    endtask : rd

    // two counter samples, with a ten cycle wait between the two reads
    task automatic gap();
        rd(`OFS_COUNTER, c1, 2'h0);
        repeat (10) @(posedge aclk);
        rd(`OFS_COUNTER, c2, 2'h0);
    endtask : gap

    task automatic test_done();
        if (bad_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    initial begin
        #400000;
        bad_count++;
        test_done();
    end

    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {cpu_idle, cpu_sleep, flt_a_n, flt_b_n} = 4'h3;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        bad_count = 0;
        checks_done = 0;
        aresetn = 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`OFS_CONTROL, c1, 2'h0);
        chk("control_reset", 32'h0, c1);
        wr(`OFS_COUNTER, 32'hffff, 2'h0);
        gap();
        chk("dir_read_only", 32'h7fff, c1);
        chk("count_off", c1, c2);
        wr(`OFS_PERIOD, 32'h64, 2'h0);
        wr(`OFS_COUNTER, 32'h0, 2'h0);
        wr(`OFS_CONTROL, 32'h8002, 2'h0);
        repeat (40) @(posedge aclk);
        rd(`OFS_COUNTER, c1, 2'h0);
        chk("dir_up", 32'h0, {31'h0, c1[15]});
        repeat (110) @(posedge aclk);
        rd(`OFS_COUNTER, c1, 2'h0);
        chk("dir_down", 32'h1, {31'h0, c1[15]});
        chk("count_field", 32'h1, {31'h0, c1[14:0] < 15'h64});
        wr(`OFS_CONTROL, 32'h0002, 2'h0);
        gap();
        chk("count_hold", c1, c2);
        wr(`OFS_PERIOD, 32'h7fff, 2'h0);
        wr(`OFS_CONTROL, 32'ha000, 2'h0);
        cpu_idle <= 1'b1;
        gap();
        chk("idle_halt", c1, c2);
        wr(`OFS_CONTROL, 32'h8000, 2'h0);
        gap();
        chk("idle_run", 32'h1, {31'h0, c1 !== c2});
        cpu_idle <= 1'b0;
        wr(`OFS_PERIOD, 32'h14, 2'h0);
        wr(`OFS_COUNTER, 32'h0, 2'h0);
        wr(`OFS_TRIGGER, 32'h800a, 2'h0);
        wr(`OFS_CONTROL, 32'h8002, 2'h0);
        pulses = 0;
        last = -100;
        // an up-phase match would come only 20 cycles after a down one
        for (int i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (trig === 1'b1) begin
                chk("trig_gap", 32'h1, {31'h0, i - last > 30});
                pulses++;
                last = i;
            end
        end
        chk("trig_seen", 32'h1, {31'h0, pulses >= 2});
        // single pulse mode: one wrap, then parked at zero
        wr(`OFS_PERIOD, 32'h5, 2'h0);
        wr(`OFS_COUNTER, 32'h0, 2'h0);
        wr(`OFS_IRQ_STATUS, 32'h7, 2'h0);
        wr(`OFS_CONTROL, 32'h8001, 2'h0);
        repeat (30) @(posedge aclk);
        gap();
        chk("single_stop", 32'h0, c1);
        chk("single_hold", c1, c2);
        rd(`OFS_IRQ_STATUS, c1, 2'h0);
        chk("wrap_status", 32'h1, {31'h0, c1[`IRQ_WRAP]});
        wr(`OFS_CONTROL, 32'h0, 2'h0);
        wr(`OFS_IRQ_STATUS, 32'h7, 2'h0);
        wr(`OFS_IRQ_MASK, 32'h1, 2'h0);
        flt_a_n <= 1'b0;
        repeat (3) @(posedge aclk);
        chk("wake_awake", 32'h0, {31'h0, wake});
        flt_a_n <= 1'b1;
        rd(`OFS_IRQ_STATUS, c1, 2'h0);
        chk("status_awake", 32'h0, c1);
        cpu_sleep <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            wr(`OFS_IRQ_MASK, {31'h0, i == 0}, 2'h0);
            flt_a_n <= (i != 0);
            flt_b_n <= (i == 0);
            repeat (3) @(posedge aclk);
            chk("wake_sleep", 32'h1, {31'h0, wake});
            flt_a_n <= 1'b1;
            flt_b_n <= 1'b1;
            rd(`OFS_IRQ_STATUS, c1, 2'h0);
            chk("status_sleep", 32'h1, c1);
            chk("irq_mask", {31'h0, i == 0}, {31'h0, irq});
            wr(`OFS_IRQ_STATUS, 32'h1, 2'h0);
            chk("irq_clear", 32'h0, {31'h0, irq});
        end
        cpu_sleep <= 1'b0;
        wr(8'h18, 32'h1, 2'h2);
        rd(8'h18, c1, 2'h2);
        chk("unmapped", 32'h0, c1);
        test_done();
    end
endmodule : pwm_time_base_lowpower_tb_top
`default_nettype wire

//--- core/pwm_tb_defines.svh
// register offsets, field positions, reset values for the pwm time base
// assumes inclusion by bare name from design files
`ifndef PWM_TB_DEFINES_SVH
`define PWM_TB_DEFINES_SVH
`define OFS_CONTROL     8'h00
`define OFS_COUNTER     8'h04
`define OFS_PERIOD      8'h08
`define OFS_TRIGGER     8'h0c
`define OFS_IRQ_STATUS  8'h10
`define OFS_IRQ_MASK    8'h14
`define BIT_ON          15
`define BIT_IDLE_STOP   13
`define BIT_DIR         15
`define BIT_TRIG_DIR    15
`define MODE_LSB        0
`define RST_CONTROL     16'h0000
`define RST_COUNTER     15'h0000
`define RST_PERIOD      15'h0000
`define IRQ_FAULT       0
`define IRQ_TRIGGER     1
`define IRQ_WRAP        2
`define IRQ_BITS        3
`endif

//--- core/pwm_tb_pkg.sv
// types shared by the pwm time base files
// assumes no other package
package pwm_tb_pkg;
    typedef enum logic [1:0] {
        MODE_FREE   = 2'h0,
        MODE_SINGLE = 2'h1,
        MODE_UPDN   = 2'h2,
        MODE_UPDN2  = 2'h3
    } tb_mode_t;
    typedef enum logic [2:0] {
        PWR_RUN   = 3'h1,
        PWR_IDLE  = 3'h2,
        PWR_SLEEP = 3'h4
    } pwr_state_t;
endpackage : pwm_tb_pkg

//--- core/pwm_time_base_lowpower.sv
// pwm time base with low-power behaviour, registers over axi4-lite
// assumes power state inputs and fault pins synchronous to aclk
`timescale 1ns/1ns
`default_nettype none
`include "pwm_tb_defines.svh"
module pwm_time_base_lowpower
    import pwm_tb_pkg::*;
(
    input  wire logic        aclk,            // clock 125 MHz
    input  wire logic        aresetn,         // sync reset, low
    input  wire logic [7:0]  s_axi_awaddr,    // write address
    input  wire logic        s_axi_awvalid,   // write address valid
    output logic             s_axi_awready,   // write address ready
    input  wire logic [31:0] s_axi_wdata,     // write data
    input  wire logic [3:0]  s_axi_wstrb,     // write strobes
    input  wire logic        s_axi_wvalid,    // write data valid
    output logic             s_axi_wready,    // write data ready
    output logic [1:0]       s_axi_bresp,     // write response
    output logic             s_axi_bvalid,    // write response valid
    input  wire logic        s_axi_bready,    // write response ready
    input  wire logic [7:0]  s_axi_araddr,    // read address
    input  wire logic        s_axi_arvalid,   // read address valid
    output logic             s_axi_arready,   // read address ready
    output logic [31:0]      s_axi_rdata,     // read data
    output logic [1:0]       s_axi_rresp,     // read response
    output logic             s_axi_rvalid,    // read data valid
    input  wire logic        s_axi_rready,    // read data ready
    input  wire logic        cpu_idle,        // processor in idle
    input  wire logic        cpu_sleep,       // processor in sleep
    input  wire logic        fault_input_a_n, // fault a, low active
    input  wire logic        fault_input_b_n, // fault b, low active
    output logic             wake_request,    // wake processor
    output logic             special_trigger, // special event pulse
    output logic             irq              // level interrupt
);
    logic [15:0]          control_reg;
    logic [14:0]          period_reg;
    logic [15:0]          trigger_reg;
    logic [`IRQ_BITS-1:0] status_reg;
    logic [`IRQ_BITS-1:0] mask_reg;
    logic [7:0]           awaddr_reg;
    logic [31:0]          wdata_reg;
    logic [3:0]           wstrb_reg;
    logic                 aw_full_reg;
    logic                 w_full_reg;
    logic                 bvalid_reg;
    logic                 bad_w_reg;
    logic [31:0]          rdata_reg;
    logic                 rvalid_reg;
    logic                 bad_r_reg;
    logic                 wake_reg;
    logic                 trig_reg;
    logic                 wr_fire;
    logic                 rd_fire;
    logic                 wr_ok;
    logic                 rd_ok;
    logic [31:0]          rd_word;
    logic                 fault_any;
    logic                 trig_hit;
    logic [`IRQ_BITS-1:0] events;
    pwr_state_t           pwr;

    tb_count_if cnt ();

    tb_counter u_counter (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cnt     (cnt)
    );

    // power state, sleep dominating idle
    always_comb begin
        if (cpu_sleep) begin
            pwr = PWR_SLEEP;
        end else if (cpu_idle) begin
            pwr = PWR_IDLE;
        end else begin
            pwr = PWR_RUN;
        end
    end

    // axi write channel: address and data taken in either order
    assign s_axi_awready = !aw_full_reg && !bvalid_reg;
    assign s_axi_wready  = !w_full_reg && !bvalid_reg;
    assign wr_fire       = aw_full_reg && w_full_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bad_w_reg ? 2'h2 : 2'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            awaddr_reg  <= 8'h00;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
            bvalid_reg  <= 1'b0;
            bad_w_reg   <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_full_reg <= 1'b0;
                w_full_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bad_w_reg   <= !wr_ok;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // write address decode
    always_comb begin
        if (awaddr_reg == `OFS_CONTROL) begin
            wr_ok = 1'b1;
        end else if (awaddr_reg == `OFS_COUNTER) begin
            wr_ok = 1'b1;
        end else if (awaddr_reg == `OFS_PERIOD) begin
            wr_ok = 1'b1;
        end else if (awaddr_reg == `OFS_TRIGGER) begin
            wr_ok = 1'b1;
        end else if (awaddr_reg == `OFS_IRQ_STATUS) begin
            wr_ok = 1'b1;
        end else if (awaddr_reg == `OFS_IRQ_MASK) begin
            wr_ok = 1'b1;
        end else begin
            wr_ok = 1'b0;
        end
    end

    // control: bits 15, 13 and 7:0 writable, others read zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control_reg <= `RST_CONTROL;
        end else if (wr_fire && awaddr_reg == `OFS_CONTROL) begin
            if (wstrb_reg[1]) begin
                control_reg[15:8] <= wdata_reg[15:8] & 8'ha0;
            end
            if (wstrb_reg[0]) begin
                control_reg[7:0] <= wdata_reg[7:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_reg  <= `RST_PERIOD;
            trigger_reg <= 16'h0000;
            mask_reg    <= {`IRQ_BITS{1'b0}};
        end else if (wr_fire) begin
            if (awaddr_reg == `OFS_PERIOD) begin
                if (wstrb_reg[1]) period_reg[14:8] <= wdata_reg[14:8];
                if (wstrb_reg[0]) period_reg[7:0]  <= wdata_reg[7:0];
            end
            if (awaddr_reg == `OFS_TRIGGER) begin
                if (wstrb_reg[1]) trigger_reg[15:8] <= wdata_reg[15:8];
                if (wstrb_reg[0]) trigger_reg[7:0]  <= wdata_reg[7:0];
            end
            if (awaddr_reg == `OFS_IRQ_MASK && wstrb_reg[0]) begin
                mask_reg <= wdata_reg[`IRQ_BITS-1:0];
            end
        end
    end

    // count load: only bits 14:0 reach the counter, bit 15 dropped
    always_comb begin
        cnt.load     = wr_fire && awaddr_reg == `OFS_COUNTER
                       && (wstrb_reg[1:0] != 2'h0);
        cnt.load_val = cnt.count;
        if (wstrb_reg[1]) cnt.load_val[14:8] = wdata_reg[14:8];
        if (wstrb_reg[0]) cnt.load_val[7:0]  = wdata_reg[7:0];
    end

    // counter steering
    assign cnt.run = control_reg[`BIT_ON]
                     && !(control_reg[`BIT_IDLE_STOP]
                          && pwr == PWR_IDLE);
    assign cnt.mode   = control_reg[`MODE_LSB+1:`MODE_LSB];
    assign cnt.period = period_reg;

    // special trigger: count match plus direction match in up/down modes
    assign trig_hit = cnt.run
        && cnt.count == trigger_reg[14:0]
        && (cnt.mode[1] == 1'b0
            || trigger_reg[`BIT_TRIG_DIR] == cnt.down);

    // fault pins and wake-up
    assign fault_any = !fault_input_a_n || !fault_input_b_n;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_reg <= 1'b0;
            trig_reg <= 1'b0;
        end else begin
            wake_reg <= (pwr == PWR_SLEEP) && fault_any;
            trig_reg <= trig_hit;
        end
    end
    assign wake_request    = wake_reg;
    assign special_trigger = trig_reg;

    // sticky status, write one to clear, set wins
    assign events[`IRQ_FAULT]   = (pwr == PWR_SLEEP) && fault_any;
    assign events[`IRQ_TRIGGER] = trig_hit;
    assign events[`IRQ_WRAP]    = cnt.wrap;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_reg <= {`IRQ_BITS{1'b0}};
        end else begin
            status_reg <= (status_reg
                & ~((wr_fire && awaddr_reg == `OFS_IRQ_STATUS
                     && wstrb_reg[0])
                    ? wdata_reg[`IRQ_BITS-1:0] : {`IRQ_BITS{1'b0}}))
                | events;
        end
    end
    assign irq = |(status_reg & mask_reg);

    // axi read channel
    assign s_axi_arready = !rvalid_reg;
    assign rd_fire       = s_axi_arvalid && s_axi_arready;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = bad_r_reg ? 2'h2 : 2'h0;

    always_comb begin
        rd_ok   = 1'b1;
        rd_word = 32'h0000_0000;
        if (s_axi_araddr == `OFS_CONTROL) begin
            rd_word[15:0] = control_reg;
        end else if (s_axi_araddr == `OFS_COUNTER) begin
            rd_word[`BIT_DIR] = cnt.down;
            rd_word[14:0]     = cnt.count;
        end else if (s_axi_araddr == `OFS_PERIOD) begin
            rd_word[14:0] = period_reg;
        end else if (s_axi_araddr == `OFS_TRIGGER) begin
            rd_word[15:0] = trigger_reg;
        end else if (s_axi_araddr == `OFS_IRQ_STATUS) begin
            rd_word[`IRQ_BITS-1:0] = status_reg;
        end else if (s_axi_araddr == `OFS_IRQ_MASK) begin
            rd_word[`IRQ_BITS-1:0] = mask_reg;
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            bad_r_reg  <= 1'b0;
        end else if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_word;
            bad_r_reg  <= !rd_ok;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end
endmodule : pwm_time_base_lowpower
`default_nettype wire

//--- core/tb_count_if.sv
// signals between the time base top and its counter core
// assumes a single clock domain
`timescale 1ns/1ns
`default_nettype none
interface tb_count_if;
    logic        run;
    logic [1:0]  mode;
    logic [14:0] period;
    logic        load;
    logic [14:0] load_val;
    logic [14:0] count;
    logic        down;
    logic        wrap;
    logic        stopped;
    modport top  (output run, mode, period, load, load_val,
                  input count, down, wrap);
    modport core (input run, mode, period, load, load_val,
                  output count, down, wrap, stopped);
endinterface : tb_count_if
`default_nettype wire

//--- core/tb_counter.sv
// 15-bit time base counter with up, up/down and single pulse modes
// assumes the top gates run for enable and idle stop
`timescale 1ns/1ns
`default_nettype none
`include "pwm_tb_defines.svh"
module tb_counter
    import pwm_tb_pkg::*;
(
    input  wire logic  aclk,     // clock
    input  wire logic  aresetn,  // sync reset, low
    tb_count_if.core   cnt       // counter link
);
    logic [14:0] count_reg;
    logic        down_reg;
    logic        wrap_reg;
    logic        done_reg;
    tb_mode_t    mode;

    assign mode        = tb_mode_t'(cnt.mode);
    assign cnt.count   = count_reg;
    assign cnt.down    = down_reg;
    assign cnt.wrap    = wrap_reg;
    assign cnt.stopped = done_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_reg <= `RST_COUNTER;
            down_reg  <= 1'b0;
            done_reg  <= 1'b0;
            wrap_reg  <= 1'b0;
        end else begin
            wrap_reg <= 1'b0;
            if (cnt.load) begin
                count_reg <= cnt.load_val;
                done_reg  <= 1'b0;
            end else if (!cnt.run) begin
                done_reg <= 1'b0;
            end else if (mode == MODE_UPDN || mode == MODE_UPDN2) begin
                if (!down_reg) begin
                    if (count_reg >= cnt.period) begin
                        down_reg  <= 1'b1;
                        count_reg <= count_reg - 15'h0001;
                        wrap_reg  <= (mode == MODE_UPDN2);
                    end else begin
                        count_reg <= count_reg + 15'h0001;
                    end
                end else begin
                    if (count_reg == 15'h0000 ||
                        count_reg == 15'h0001) begin
                        down_reg  <= 1'b0;
                        wrap_reg  <= (count_reg == 15'h0001);
                    end
                    if (count_reg != 15'h0000) begin
                        count_reg <= count_reg - 15'h0001;
                    end
                end
            end else begin
                down_reg <= 1'b0;
                if (done_reg) begin
                    count_reg <= count_reg;
                end else if (count_reg >= cnt.period) begin
                    count_reg <= 15'h0000;
                    wrap_reg  <= 1'b1;
                    done_reg  <= (mode == MODE_SINGLE);
                end else begin
                    count_reg <= count_reg + 15'h0001;
                end
            end
        end
    end
endmodule : tb_counter
`default_nettype wire
